//--- hw/odsu_pkg.sv
// Shared constants and types for the octal DAC serial update control.
package odsu_pkg;
  localparam int unsigned FRAME_BITS    = 16;
  localparam int unsigned CHANNELS      = 8;
  localparam int unsigned DATA_W        = 12;
  localparam int unsigned CNT_W         = 5;
  localparam int unsigned BIT_CTRL      = 15;
  localparam int unsigned BIT_MODE_HI   = 14;
  localparam int unsigned BIT_MODE_LO   = 13;
  localparam int unsigned BIT_RST_FULL  = 12;
  localparam int unsigned BIT_ADDR_HI   = 14;
  localparam int unsigned BIT_ADDR_LO   = 12;
  localparam int unsigned BIT_DATA_HI   = 11;
  localparam int unsigned BIT_CFG_HI    = 5;
  localparam int unsigned BIT_LDM_HI    = 1;
  localparam logic [1:0]  MODE_REF_GAIN = 2'h0;
  localparam logic [1:0]  MODE_LOAD_DAC_N     = 2'h1;
  localparam logic [1:0]  MODE_PWRDN    = 2'h2;
  localparam logic [1:0]  MODE_RESET    = 2'h3;
  localparam logic [1:0]  LDM_LOW       = 2'h0;
  localparam logic [1:0]  LDM_HIGH      = 2'h1;
  localparam logic [1:0]  LDM_SINGLE    = 2'h2;
  localparam logic [1:0]  LDM_RST       = LDM_HIGH;
  localparam logic [5:0]  CFG_RST       = 6'h00;
  localparam logic [7:0]  PWRDN_RST     = 8'h00;
  localparam int unsigned HOST_DIV      = 4;
  localparam int unsigned HOST_DIV_W    = 3;
  typedef logic [DATA_W-1:0] odsu_data_t;
endpackage : odsu_pkg

//--- hw/odsu_link_if.sv
// Three-wire serial link plus load strobe between host and DAC control.
`timescale 1ns/10ps
`default_nettype none
interface odsu_link_if;
  logic frame_n;
  logic sclk;
  logic sdin;
  logic load_dac_n;
  modport host (output frame_n, output sclk, output sdin, output load_dac_n);
  modport dev  (input frame_n, input sclk, input sdin, input load_dac_n);
endinterface : odsu_link_if
`default_nettype wire

//--- hw/odsu_dev.sv
// Device end: frame receiver, command decode and double-buffered DAC registers.
`timescale 1ns/10ps
`default_nettype none
module odsu_dev
  import odsu_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic          ce,
  odsu_link_if.dev           link,
  output logic [CHANNELS*DATA_W-1:0] dac_code,
  output logic [CHANNELS-1:0]        pwrdn,
  output logic [5:0]                 cfg_active,
  output logic [1:0]                 load_mode,
  output logic                       frame_done
);
  // Pins cross from the link into the clock domain through two flip-flops.
  logic [2:0]          frm_s_r;
  logic [2:0]          sck_s_r;
  logic [1:0]          din_s_r;
  logic [1:0]          ld_s_r;
  logic [FRAME_BITS-1:0] shift_r;
  logic [CNT_W-1:0]    cnt_r;
  odsu_data_t          in_reg_r  [CHANNELS];
  odsu_data_t          dac_reg_r [CHANNELS];
  logic [CHANNELS-1:0] dirty_r;
  logic [5:0]          cfg_in_r;
  logic                cfg_dirty_r;
  logic                single_r;
  logic                done_r;
  logic                sck_fall;
  logic                frm_rise;
  logic                ld_low;
  logic [2:0]          ld_str_r;
  logic                load_now;
  logic [FRAME_BITS-1:0] word;

  // Channel field of a data write; the write and its dirty mark must agree on it.
  function automatic logic [2:0] chan_of(input logic [FRAME_BITS-1:0] w);
    return w[BIT_ADDR_HI:BIT_ADDR_LO];
  endfunction : chan_of

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      frm_s_r <= 3'h7;
      sck_s_r <= 3'h0;
      din_s_r <= 2'h0;
      ld_s_r  <= 2'h3;
    end else if (ce) begin
      frm_s_r <= {frm_s_r[1:0], link.frame_n};
      sck_s_r <= {sck_s_r[1:0], link.sclk};
      din_s_r <= {din_s_r[0], link.sdin};
      ld_s_r  <= {ld_s_r[0], link.load_dac_n};
    end
  end

  assign sck_fall = sck_s_r[2] & ~sck_s_r[1] & ~frm_s_r[1];
  assign frm_rise = ~frm_s_r[2] & frm_s_r[1];
  assign word     = shift_r;

  // Frame counter; a frame is taken when frame rises after 16 or more edges, and edges beyond 16 are not shifted in.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shift_r <= 16'h0000;
      cnt_r   <= 5'h00;
    end else if (ce) begin
      if (frm_s_r[1]) begin
        cnt_r <= 5'h00;
      end else if (sck_fall && cnt_r < CNT_W'(FRAME_BITS)) begin
        shift_r <= {shift_r[FRAME_BITS-2:0], din_s_r[1]};
        cnt_r   <= cnt_r + 5'h01;
      end
    end
  end

  // Completion on the rising frame edge keeps a late extra edge from corrupting the word.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      done_r <= 1'b0;
    end else if (ce) begin
      done_r <= frm_rise && cnt_r == CNT_W'(FRAME_BITS);
    end
  end

  logic is_ctrl;
  logic [1:0] mode;
  assign is_ctrl = word[BIT_CTRL];
  assign mode    = word[BIT_MODE_HI:BIT_MODE_LO];

  // A strobe given at frame close passes its synchroniser before the frame path writes the word.
  // Its low level is therefore stretched by three cycles, at the price of an equally short late load window.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ld_str_r <= 3'h0;
    end else if (ce) begin
      ld_str_r <= {ld_str_r[1:0], !ld_s_r[1]};
    end
  end

  assign ld_low = !ld_s_r[1] || ld_str_r != 3'h0;

  // Pin low or mode 00 makes the DAC registers transparent; single mode loads once.
  assign load_now = ld_low || load_mode == LDM_LOW || single_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      load_mode <= LDM_RST;
      pwrdn     <= PWRDN_RST;
      cfg_in_r  <= CFG_RST;
      single_r  <= 1'b0;
    end else if (ce) begin
      single_r <= 1'b0;
      if (done_r && is_ctrl) begin
        case (mode)
          MODE_REF_GAIN: cfg_in_r <= word[BIT_CFG_HI:0];
          MODE_LOAD_DAC_N: begin
            if (word[BIT_LDM_HI:0] == LDM_SINGLE) begin
              single_r  <= 1'b1;
              load_mode <= LDM_HIGH;
            end else if (word[BIT_LDM_HI:0] != 2'h3) begin
              load_mode <= word[BIT_LDM_HI:0];
            end
          end
          MODE_PWRDN: pwrdn <= word[CHANNELS-1:0];
          default: begin
            if (word[BIT_RST_FULL]) begin
              load_mode <= LDM_RST;
              pwrdn     <= PWRDN_RST;
              cfg_in_r  <= CFG_RST;
            end
          end
        endcase
      end
    end
  end

  // Data path; a write then load in the same cycle is covered by the dirty flag next cycle.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < CHANNELS; i++) begin
        in_reg_r[i]  <= '0;
        dac_reg_r[i] <= '0;
      end
      dirty_r     <= '0;
      cfg_active  <= CFG_RST;
      cfg_dirty_r <= 1'b0;
    end else if (ce) begin
      if (load_now) begin
        for (int i = 0; i < CHANNELS; i++) begin
          if (dirty_r[i]) begin
            dac_reg_r[i] <= in_reg_r[i];
            dirty_r[i]   <= 1'b0;
          end
        end
        if (cfg_dirty_r) begin
          cfg_active  <= cfg_in_r;
          cfg_dirty_r <= 1'b0;
        end
      end
      if (done_r && !is_ctrl) begin
        in_reg_r[chan_of(word)] <= word[BIT_DATA_HI:0];
        dirty_r[chan_of(word)]  <= 1'b1;
      end
      if (done_r && is_ctrl && mode == MODE_REF_GAIN) begin
        cfg_dirty_r <= 1'b1;
      end
      if (done_r && is_ctrl && mode == MODE_RESET) begin
        for (int i = 0; i < CHANNELS; i++) begin
          in_reg_r[i]  <= '0;
          dac_reg_r[i] <= '0;
        end
        dirty_r <= '0;
        if (word[BIT_RST_FULL]) begin
          cfg_active  <= CFG_RST;
          cfg_dirty_r <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      dac_code[i*DATA_W +: DATA_W] = dac_reg_r[i];
    end
  end

  assign frame_done = done_r;
endmodule : odsu_dev
`default_nettype wire

//--- hw/odsu_host.sv
// Host end: sends one 16-bit frame MSB first and drives the load strobe.
`timescale 1ns/10ps
`default_nettype none
module odsu_host
  import odsu_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  input  wire logic                  req_valid,
  input  wire logic [FRAME_BITS-1:0] req_word,
  input  wire logic                  req_load,
  output logic                       req_ready,
  output logic                       req_done,
  odsu_link_if.host                  link
);
  typedef enum logic [1:0] {ODSU_IDLE, ODSU_SHIFT, ODSU_END} odsu_state_e;
  odsu_state_e            state_r;
  logic [FRAME_BITS-1:0]  sh_r;
  logic [CNT_W-1:0]       bit_r;
  logic [HOST_DIV_W-1:0]  div_r;
  logic                   sck_r;
  logic                   frm_r;
  logic                   ld_r;
  logic                   load_req_r;
  logic                   done_r;

  // The link clock is derived by a divider; idle low gives CPOL 0.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r    <= ODSU_IDLE;
      sh_r       <= 16'h0000;
      bit_r      <= 5'h00;
      div_r      <= 3'h0;
      sck_r      <= 1'b0;
      frm_r      <= 1'b1;
      ld_r       <= 1'b1;
      load_req_r <= 1'b0;
      done_r     <= 1'b0;
    end else if (ce) begin
      done_r <= 1'b0;
      ld_r   <= 1'b1;
      case (state_r)
        ODSU_IDLE: begin
          if (req_valid) begin
            sh_r       <= req_word;
            load_req_r <= req_load;
            frm_r      <= 1'b0;
            bit_r      <= 5'h00;
            div_r      <= 3'h0;
            state_r    <= ODSU_SHIFT;
          end
        end
        ODSU_SHIFT: begin
          div_r <= div_r + 3'h1;
          if (div_r == HOST_DIV_W'(HOST_DIV - 1)) begin
            div_r <= 3'h0;
            sck_r <= ~sck_r;
            if (sck_r) begin
              bit_r <= bit_r + 5'h01;
              if (bit_r == CNT_W'(FRAME_BITS - 1)) begin
                state_r <= ODSU_END;
              end
            end else if (bit_r != 5'h00) begin
              sh_r <= {sh_r[FRAME_BITS-2:0], 1'b0};
            end
          end
        end
        default: begin
          div_r <= div_r + 3'h1;
          if (div_r == HOST_DIV_W'(HOST_DIV - 1)) begin
            frm_r   <= 1'b1;
            ld_r    <= ~load_req_r;
            done_r  <= 1'b1;
            state_r <= ODSU_IDLE;
          end
        end
      endcase
    end
  end

  assign link.frame_n    = frm_r;
  assign link.sclk       = sck_r;
  assign link.sdin       = sh_r[FRAME_BITS-1];
  assign link.load_dac_n = ld_r;
  assign req_ready       = state_r == ODSU_IDLE;
  assign req_done        = done_r;
endmodule : odsu_host
`default_nettype wire

//--- verif/odsu_link_asserts.sv
// Protocol checker watching the serial link between host and device ends.
`timescale 1ns/10ps
`default_nettype none
module odsu_link_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic frame_n,
  input wire logic sclk,
  input wire logic sdin,
  input wire logic load_dac_n
);
  logic [4:0] falls_r;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Counts falling link clock edges so a short or long frame shows at its close.
  always_ff @(posedge clock) begin
    if (!rst_n || frame_n) begin
      falls_r <= 5'h00;
    end else if ($fell(sclk)) begin
      falls_r <= falls_r + 5'h01;
    end
  end
  a_clock_idle_low: assert property (frame_n |-> !sclk)
    else $error("link clock high outside a frame");
  a_high_phase: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("link clock high phase is not four cycles");
  a_low_phase: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("link clock low phase too short");
  a_sixteen_falls: assert property ($rose(frame_n) |-> falls_r == 5'h10)
    else $error("frame closed without sixteen falling edges");
  a_frame_length: assert property ($fell(frame_n) |-> ##[120:140] $rose(frame_n))
    else $error("frame select not held low for the whole word");
  a_data_stable: assert property (sclk && $past(sclk) |-> $stable(sdin))
    else $error("serial data moved while link clock high");
  a_load_pulse: assert property ($fell(load_dac_n) |=> load_dac_n)
    else $error("load strobe longer than one cycle");
  a_load_outside: assert property (!load_dac_n |-> frame_n)
    else $error("load strobe inside a frame");
endmodule : odsu_link_asserts
`default_nettype wire

//--- verif/tb.sv
// Bench: host and device joined on one link, a second device fed by hand for aborted frames.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import odsu_pkg::*;
  logic                       clock, rst_n, req_valid, req_load, req_ready, req_done, done_b;
  logic [FRAME_BITS-1:0]      req_word;
  logic [CHANNELS*DATA_W-1:0] dac_code, dac_b, dac_m;
  logic [CHANNELS-1:0]        pwrdn, pwr_m, dirty_m;
  logic [5:0]                 cfg_active, cfg_in_m, cfg_m;
  logic [1:0]                 load_mode, ldm_m;
  odsu_data_t                 in_m [CHANNELS];
  int                         n_errors, checks, cyc, n_done_b;
  logic [16:0] corner [12] = '{17'h01123, 17'h08015, 17'h12456, 17'h0C0A5, 17'h0A000, 17'h03789,
                               17'h0A002, 17'h04ABC, 17'h15DEF, 17'h0A003, 17'h0E000, 17'h0F000};
  odsu_link_if link_i ();
  odsu_link_if link_b ();
  odsu_host odsu_host_i (.clock(clock), .rst_n(rst_n), .ce(1'b1), .req_valid(req_valid), .req_word(req_word),
                         .req_load(req_load), .req_ready(req_ready), .req_done(req_done), .link(link_i.host));
  odsu_dev odsu_dev_i (.clock(clock), .rst_n(rst_n), .ce(1'b1), .link(link_i.dev), .dac_code(dac_code),
                       .pwrdn(pwrdn), .cfg_active(cfg_active), .load_mode(load_mode), .frame_done());
  odsu_dev odsu_dev_i2 (.clock(clock), .rst_n(rst_n), .ce(1'b1), .link(link_b.dev), .dac_code(dac_b), .pwrdn(),
                        .cfg_active(), .load_mode(), .frame_done(done_b));
  odsu_link_asserts odsu_link_asserts_i (.clock(clock), .rst_n(rst_n), .frame_n(link_i.frame_n),
                                         .sclk(link_i.sclk), .sdin(link_i.sdin), .load_dac_n(link_i.load_dac_n));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    n_done_b <= n_done_b + int'(done_b);
    if (cyc == 40000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  function automatic void expect_frame(input logic [15:0] w, input logic ld);
    logic xfer;
    xfer = ld;
    if (!w[BIT_CTRL]) begin
      in_m[w[14:12]] = w[11:0];
      dirty_m[w[14:12]] = 1'b1;
    end else case (w[14:13])
      MODE_REF_GAIN: cfg_in_m = w[5:0];
      MODE_LOAD_DAC_N: if (w[1:0] != 2'h3) begin
        ldm_m = (w[1:0] == LDM_SINGLE) ? LDM_HIGH : w[1:0];
        xfer |= (w[1:0] == LDM_SINGLE);
      end
      MODE_PWRDN: pwr_m = w[7:0];
      default: begin
        in_m = '{default: '0};
        {dac_m, dirty_m} = '0;
        if (w[BIT_RST_FULL]) begin
          {cfg_in_m, cfg_m, pwr_m} = '0;
          ldm_m = LDM_RST;
        end
      end
    endcase
    if (xfer || ldm_m == LDM_LOW) begin
      for (int c = 0; c < CHANNELS; c++) if (dirty_m[c]) dac_m[c*DATA_W+:DATA_W] = in_m[c];
      dirty_m = '0;
      cfg_m = cfg_in_m;
    end
  endfunction : expect_frame
  task automatic send(input logic [15:0] w, input logic ld);
    req_valid <= 1'b1;
    req_word <= w;
    req_load <= ld;
    do @(posedge clock); while (!req_ready);
    req_valid <= 1'b0;
    req_load <= 1'b0;
    for (int i = 0; i < 300 && !req_done; i++) @(posedge clock);
    chk(96'(req_done), 96'h1);
    // Margin covers the pin synchronisers and the input then DAC register steps.
    repeat (12) @(posedge clock);
    expect_frame(w, ld);
    chk(dac_code, dac_m);
    chk(pwrdn, pwr_m);
    chk(cfg_active, cfg_m);
    chk(load_mode, ldm_m);
  endtask : send
  task automatic bb_frame(input logic [15:0] w, input int nb);
    link_b.frame_n <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      repeat (6 + i % 2) @(posedge clock);
      link_b.sclk <= 1'b1;
      link_b.sdin <= w[15 - i];
      repeat (6) @(posedge clock);
      link_b.sclk <= 1'b0;
    end
    repeat (6) @(posedge clock);
    link_b.frame_n <= 1'b1;
    link_b.sdin <= ~link_b.sdin;
    repeat (12) @(posedge clock);
  endtask : bb_frame
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_load = 1'b0;
    req_word = '0;
    link_b.frame_n = 1'b1;
    link_b.sclk = 1'b0;
    link_b.sdin = 1'b0;
    link_b.load_dac_n = 1'b1;
    in_m = '{default: '0};
    {dac_m, pwr_m, dirty_m, cfg_in_m, cfg_m} = '0;
    ldm_m = LDM_RST;
    void'($urandom(95748));
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    foreach (corner[i]) send(corner[i][15:0], corner[i][16]);
    $display("test corners done");
    for (int c = 0; c < 8; c++) send({1'b0, 3'(c), 12'(c * 273)}, c == 7);
    $display("test simultaneous done");
    for (int i = 0; i < 40; i++) send(16'($urandom), 1'($urandom));
    $display("test random done");
    bb_frame(16'hA000, 16);
    bb_frame(16'h1ABC, 15);
    chk(dac_b, '0);
    chk(n_done_b, 1);
    bb_frame(16'h1ABC, 16);
    chk(dac_b[DATA_W+:DATA_W], 12'hABC);
    $display("test abort done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
